/* hdl/tcc_pkg.sv */
package tcc_pkg;

   // register byte addresses on the plain register port
   localparam logic [3:0] ADDR_RUN    = 4'h0;
   localparam logic [3:0] ADDR_MODE   = 4'h1;
   localparam logic [3:0] ADDR_FFCTRL = 4'h2;
   localparam logic [3:0] ADDR_DBCTL  = 4'h3;
   localparam logic [3:0] ADDR_CMPF_L = 4'h4;
   localparam logic [3:0] ADDR_CMPF_H = 4'h5;
   localparam logic [3:0] ADDR_CMPS_L = 4'h6;
   localparam logic [3:0] ADDR_CMPS_H = 4'h7;
   localparam logic [3:0] ADDR_CAPA_L = 4'h8;
   localparam logic [3:0] ADDR_CAPA_H = 4'h9;
   localparam logic [3:0] ADDR_CAPB_L = 4'hA;
   localparam logic [3:0] ADDR_CAPB_H = 4'hB;
   localparam logic [3:0] ADDR_STATUS = 4'hC;
   localparam logic [3:0] ADDR_PORTFN = 4'hD;

   // bit positions of the run, buffer, status and port function bytes
   localparam int unsigned RUN_TMR_BIT = 0;
   localparam int unsigned RUN_PRE_BIT = 7;
   localparam int unsigned DB_EN_BIT   = 0;
   localparam int unsigned OUT_1_BIT   = 0;
   localparam int unsigned OUT_2_BIT   = 1;

   // reset values
   localparam logic [7:0]  RUN_RST    = 8'h00;
   localparam logic [7:0]  MODE_RST   = 8'h00;
   localparam logic [7:0]  FFCTRL_RST = 8'hC3;
   localparam logic [7:0]  DBCTL_RST  = 8'h00;
   localparam logic [7:0]  PORTFN_RST = 8'h00;
   localparam logic [15:0] CMP_RST    = 16'hFFFF;
   localparam logic [15:0] CNT_MAX    = 16'hFFFF;

   // prescaler taps: a tap of n bits ticks once per 2**n clocks
   localparam int unsigned PRE_BITS   = 5;
   localparam int unsigned PRE_T1_TAP = 1;
   localparam int unsigned PRE_T4_TAP = 3;
   localparam int unsigned PRE_T16_TAP = 5;

   // count source select
   typedef enum logic [1:0] {
      CLK_EXT = 2'b00,
      CLK_T1  = 2'b01,
      CLK_T4  = 2'b10,
      CLK_T16 = 2'b11
   } tcc_clksel_e;

   // capture timing select
   typedef enum logic [1:0] {
      CAP_OFF   = 2'b00,
      CAP_PINS  = 2'b01,
      CAP_PULSE = 2'b10,
      CAP_FF    = 2'b11
   } tcc_capsel_e;

   // software command to a timer flip-flop
   typedef enum logic [1:0] {
      FF_INVERT = 2'b00,
      FF_CLEAR  = 2'b01,
      FF_SET    = 2'b10,
      FF_HOLD   = 2'b11
   } tcc_ffcmd_e;

   // timer mode byte
   typedef struct packed {
      logic        trigMatchSecond;
      logic        trigCapA;
      logic        softCaptureReq;
      tcc_capsel_e captureTimingSel;
      logic        clearEn;
      tcc_clksel_e clkSel;
   } tcc_mode_s;

   // flip-flop control byte
   typedef struct packed {
      tcc_ffcmd_e softCtrlSecond;
      logic       trigMatchSecond;
      logic       trigMatchFirst;
      logic       trigCapB;
      logic       trigCapA;
      tcc_ffcmd_e softCtrlFirst;
   } tcc_ffctrl_s;

endpackage : tcc_pkg

/* hdl/tcc_prescaler.sv */
`timescale 1ns/1ps
module tcc_prescaler
   import tcc_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // control
   input  wire logic run,
   // divided ticks, one cycle each
   output logic      tickT1,
   output logic      tickT4,
   output logic      tickT16
);

   logic [PRE_BITS-1:0] divReg;   // free divider, held at zero when stopped

   // divider counts only while the prescaler run bit is set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         divReg <= '0;
      end else if (!run) begin
         divReg <= '0;
      end else begin
         divReg <= divReg + 1'b1;
      end
   end

   // a tap fires when all of its low bits are ones
   assign tickT1  = run && (&divReg[PRE_T1_TAP-1:0]);
   assign tickT4  = run && (&divReg[PRE_T4_TAP-1:0]);
   assign tickT16 = run && (&divReg[PRE_T16_TAP-1:0]);

endmodule : tcc_prescaler

/* hdl/tcc_edge_detect.sv */
`timescale 1ns/1ps
module tcc_edge_detect
   import tcc_pkg::*;
#(
   parameter int unsigned WIDTH = 3
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // sampled levels
   input  wire logic [WIDTH-1:0] level,
   // edge pulses, one cycle each
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] prevReg;   // level one clock ago

   // remember last level; inputs are already synchronous
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prevReg <= '0;
      end else begin
         prevReg <= level;
      end
   end

   assign rise = level & ~prevReg;
   assign fall = ~level & prevReg;

endmodule : tcc_edge_detect

/* hdl/tcc_timer.sv */
//Behaviour
//- capture registers hold 16-bit counter snapshots
//- capture registers ignore software writes
//- selector 00 disables pin capture; reset selects it
//- selector 01: input rises load A, B
//- selector 10: first input rise A, fall B
//- edge interrupt on fall only under 10
//- selector 11: 8-bit flip-flop edges load A/B
//- writing 0 to request captures into A
//- each compare equality gives match interrupt
//- second match clears counter unless disabled
//- first flip-flop toggles on four enabled triggers
//- second flip-flop toggles on two enabled triggers
//- soft field: 01 clear, 10 set, 00 invert
//- flip-flops drive pins when routed there
//- event mode counts first input rising edges
//- event input needs no function selection
//- counter overflow raises overflow interrupt
//- buffered first compare loads at second match
//- reset stops all; run 0 clears counter
`timescale 1ns/1ps
module tcc_timer
   import tcc_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // register port
   input  wire logic [3:0] busAddr,
   input  wire logic [7:0] busWdata,
   input  wire logic       busWrite,
   input  wire logic       busRead,
   output logic      [7:0] busRdata,
   // trigger inputs
   input  wire logic       timerInputFirst,
   input  wire logic       timerInputSecond,
   input  wire logic       eightBitTimerFlipflop,
   // timer output pins
   output logic            timerOutputFirst,
   output logic            timerOutputFirstEn,
   output logic            timerOutputSecond,
   output logic            timerOutputSecondEn,
   // interrupt request pulses
   output logic            matchIrqFirst,
   output logic            matchIrqSecond,
   output logic            overflowIrq,
   output logic            edgeInputIrq
);

   ////////////////////////////////////////////////////////////////////////
   // declarations
   logic [7:0]  runControlReg;      // timer and prescaler run bits
   tcc_mode_s   timerModeReg;       // mode, capture select, ff2 triggers
   tcc_ffctrl_s flipflopCtrlReg;    // ff1 triggers; soft fields unused
   logic [7:0]  dbCtrlReg;          // double buffer enable
   logic [7:0]  portFunctionReg;    // routes flip-flops to pins
   logic [15:0] upCounter;          // the counter itself
   logic [15:0] compareRegFirst;    // active first compare value
   logic [15:0] compareBufFirst;    // buffer behind first compare
   logic [15:0] compareRegSecond;   // second compare value
   logic [7:0]  cmpLowTemp;         // low byte waiting for its high byte
   logic [15:0] captureRegA;        // snapshot A
   logic [15:0] captureRegB;        // snapshot B
   logic [7:0]  capShadowA;         // high byte frozen at low byte read
   logic [7:0]  capShadowB;
   logic [7:0]  readMux;            // combinational read value
   logic [2:0]  edgeRise;           // pin edges: first, second, 8-bit ff
   logic [2:0]  edgeFall;
   logic        tickT1;
   logic        tickT4;
   logic        tickT16;
   logic        srcTick;            // selected count source
   logic        countTick;          // a count step happens this cycle
   logic        atClear;            // next step returns to zero
   logic [15:0] cntNext;            // value after this step
   logic        matchFirstHit;      // step lands on first compare
   logic        matchSecondHit;     // step lands on second compare
   logic        softCap;            // software capture request
   logic        capAEv;
   logic        capBEv;
   logic        ffWrite;
   tcc_ffctrl_s ffCmd;              // write data seen as ff control
   logic        trigFirst;
   logic        trigSecond;
   logic        runTmr;
   logic        runPre;
   logic        dbEn;
   tcc_capsel_e capSel;

   // true when a write strobe targets the given address
   function automatic logic wrAt(input logic [3:0] a,
                                 input logic       we,
                                 input logic [3:0] addr);
      return we && (addr == a);
   endfunction : wrAt

   ////////////////////////////////////////////////////////////////////////
   // helpers
   tcc_prescaler u_prescaler (
      .clk     (clk),
      .rst_n   (rst_n),
      .run     (runPre),
      .tickT1  (tickT1),
      .tickT4  (tickT4),
      .tickT16 (tickT16)
   );

   tcc_edge_detect #(.WIDTH(3)) u_edges (
      .clk   (clk),
      .rst_n (rst_n),
      .level ({eightBitTimerFlipflop, timerInputSecond, timerInputFirst}),
      .rise  (edgeRise),
      .fall  (edgeFall)
   );

   assign runTmr = runControlReg[RUN_TMR_BIT];
   assign runPre = runControlReg[RUN_PRE_BIT];
   assign dbEn   = dbCtrlReg[DB_EN_BIT];
   assign capSel = timerModeReg.captureTimingSel;

   ////////////////////////////////////////////////////////////////////////
   // control registers; reset leaves the timer stopped, capture off
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         runControlReg   <= RUN_RST;
         timerModeReg    <= tcc_mode_s'(MODE_RST);
         flipflopCtrlReg <= tcc_ffctrl_s'(FFCTRL_RST);
         dbCtrlReg       <= DBCTL_RST;
         portFunctionReg <= PORTFN_RST;
      end else begin
         if (wrAt(ADDR_RUN, busWrite, busAddr)) begin
            runControlReg <= busWdata;
         end
         if (wrAt(ADDR_MODE, busWrite, busAddr)) begin
            timerModeReg <= tcc_mode_s'(busWdata);
         end
         if (ffWrite) begin
            flipflopCtrlReg <= ffCmd;
         end
         if (wrAt(ADDR_DBCTL, busWrite, busAddr)) begin
            dbCtrlReg <= busWdata;
         end
         if (wrAt(ADDR_PORTFN, busWrite, busAddr)) begin
            portFunctionReg <= busWdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counting; external source is the first input, no pin select needed
   always_comb begin
      unique case (timerModeReg.clkSel)
         CLK_EXT: srcTick = edgeRise[0];
         CLK_T1:  srcTick = tickT1;
         CLK_T4:  srcTick = tickT4;
         CLK_T16: srcTick = tickT16;
      endcase
   end

   // the prescaler gates external edges too, so stopping it freezes all
   assign countTick = runTmr && runPre && srcTick;
   assign atClear   = timerModeReg.clearEn &&
                      (upCounter == compareRegSecond);
   assign cntNext   = atClear ? 16'h0000 : upCounter + 16'h0001;
   assign matchFirstHit  = countTick && (cntNext == compareRegFirst);
   assign matchSecondHit = countTick && (cntNext == compareRegSecond);

   // counter sits on the match value until the next step clears it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         upCounter <= 16'h0000;
      end else if (!runTmr) begin
         upCounter <= 16'h0000;
      end else if (countTick) begin
         upCounter <= cntNext;
      end
   end

   // interrupt pulses, registered so they are glitch free
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         matchIrqFirst  <= 1'b0;
         matchIrqSecond <= 1'b0;
         overflowIrq    <= 1'b0;
         edgeInputIrq   <= 1'b0;
      end else begin
         matchIrqFirst  <= matchFirstHit;
         matchIrqSecond <= matchSecondHit;
         overflowIrq    <= countTick && !atClear &&
                           (upCounter == CNT_MAX);
         edgeInputIrq   <= (capSel == CAP_PULSE) ? edgeFall[0]
                                                 : edgeRise[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // compare registers; writes commit on the high byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmpLowTemp       <= 8'h00;
         compareRegFirst  <= CMP_RST;
         compareBufFirst  <= CMP_RST;
         compareRegSecond <= CMP_RST;
      end else begin
         if (wrAt(ADDR_CMPF_L, busWrite, busAddr) ||
             wrAt(ADDR_CMPS_L, busWrite, busAddr)) begin
            cmpLowTemp <= busWdata;
         end
         if (wrAt(ADDR_CMPF_H, busWrite, busAddr)) begin
            compareBufFirst <= {busWdata, cmpLowTemp};
         end
         // buffer off: write goes straight through; on: loads at match
         if (!dbEn && wrAt(ADDR_CMPF_H, busWrite, busAddr)) begin
            compareRegFirst <= {busWdata, cmpLowTemp};
         end else if (dbEn && matchSecondHit) begin
            compareRegFirst <= compareBufFirst;
         end
         if (wrAt(ADDR_CMPS_H, busWrite, busAddr)) begin
            compareRegSecond <= {busWdata, cmpLowTemp};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // capture events
   assign softCap = wrAt(ADDR_MODE, busWrite, busAddr) &&
                    !busWdata[5];
   assign capAEv  = softCap ||
                    ((capSel == CAP_PINS) && edgeRise[0]) ||
                    ((capSel == CAP_PULSE) && edgeRise[0]) ||
                    ((capSel == CAP_FF) && edgeRise[2]);
   assign capBEv  = ((capSel == CAP_PINS) && edgeRise[1]) ||
                    ((capSel == CAP_PULSE) && edgeFall[0]) ||
                    ((capSel == CAP_FF) && edgeFall[2]);

   // snapshots; no bus path writes these, so writes are dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         captureRegA <= 16'h0000;
         captureRegB <= 16'h0000;
      end else begin
         if (capAEv) begin
            captureRegA <= upCounter;
         end
         if (capBEv) begin
            captureRegB <= upCounter;
         end
      end
   end

   // freeze the high byte when the low byte is read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         capShadowA <= 8'h00;
         capShadowB <= 8'h00;
      end else begin
         if (busRead && (busAddr == ADDR_CAPA_L)) begin
            capShadowA <= captureRegA[15:8];
         end
         if (busRead && (busAddr == ADDR_CAPB_L)) begin
            capShadowB <= captureRegB[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timer flip-flops; a software command beats a trigger
   assign ffWrite    = wrAt(ADDR_FFCTRL, busWrite, busAddr);
   assign ffCmd      = tcc_ffctrl_s'(busWdata);
   assign trigFirst  = (flipflopCtrlReg.trigCapA && capAEv) ||
                       (flipflopCtrlReg.trigCapB && capBEv) ||
                       (flipflopCtrlReg.trigMatchFirst && matchFirstHit) ||
                       (flipflopCtrlReg.trigMatchSecond && matchSecondHit);
   assign trigSecond = (timerModeReg.trigCapA && capAEv) ||
                       (timerModeReg.trigMatchSecond && matchSecondHit);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timerOutputFirst <= 1'b0;
      end else if (ffWrite && (ffCmd.softCtrlFirst != FF_HOLD)) begin
         unique case (ffCmd.softCtrlFirst)
            FF_CLEAR:  timerOutputFirst <= 1'b0;
            FF_SET:    timerOutputFirst <= 1'b1;
            FF_INVERT: timerOutputFirst <= !timerOutputFirst;
            FF_HOLD:   timerOutputFirst <= timerOutputFirst;
         endcase
      end else if (trigFirst) begin
         timerOutputFirst <= !timerOutputFirst;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timerOutputSecond <= 1'b0;
      end else if (ffWrite && (ffCmd.softCtrlSecond != FF_HOLD)) begin
         unique case (ffCmd.softCtrlSecond)
            FF_CLEAR:  timerOutputSecond <= 1'b0;
            FF_SET:    timerOutputSecond <= 1'b1;
            FF_INVERT: timerOutputSecond <= !timerOutputSecond;
            FF_HOLD:   timerOutputSecond <= timerOutputSecond;
         endcase
      end else if (trigSecond) begin
         timerOutputSecond <= !timerOutputSecond;
      end
   end

   // pin drive follows the port function bits
   assign timerOutputFirstEn  = portFunctionReg[OUT_1_BIT];
   assign timerOutputSecondEn = portFunctionReg[OUT_2_BIT];

   ////////////////////////////////////////////////////////////////////////
   // read path; compare registers are write only and read zero
   always_comb begin
      readMux = 8'h00;
      unique case (busAddr)
         ADDR_RUN:    readMux = runControlReg;
         ADDR_MODE:   readMux = timerModeReg | 8'h20;
         ADDR_FFCTRL: readMux = flipflopCtrlReg | 8'hC3;
         ADDR_DBCTL:  readMux = dbCtrlReg;
         ADDR_CAPA_L: readMux = captureRegA[7:0];
         ADDR_CAPA_H: readMux = capShadowA;
         ADDR_CAPB_L: readMux = captureRegB[7:0];
         ADDR_CAPB_H: readMux = capShadowB;
         ADDR_STATUS: readMux = {6'h00, timerOutputSecond, timerOutputFirst};
         ADDR_PORTFN: readMux = portFunctionReg;
         default:     readMux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busRdata <= 8'h00;
      end else begin
         busRdata <= busRead ? readMux : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic [7:0] capAHigh;
   assign capAHigh = captureRegA[15:8];

   sequence s_lowReadA;
      busRead && (busAddr == ADDR_CAPA_L);
   endsequence
   sequence s_highReadA;
      busRead && (busAddr == ADDR_CAPA_H);
   endsequence

   a_cap_coherent: assert property (s_lowReadA ##1 s_highReadA |=>
      busRdata == $past(capAHigh, 2)) else $error("capture pair torn");
   a_cap_disabled: assert property ((capSel == CAP_OFF) && !softCap
      |=> $stable(captureRegA) && $stable(captureRegB))
      else $error("capture while disabled");
   a_cap_pins_b: assert property ((capSel == CAP_PINS) && edgeRise[1]
      |=> captureRegB == $past(upCounter)) else $error("pin B capture");
   a_cap_pulse_b: assert property ((capSel == CAP_PULSE) && edgeFall[0]
      |=> captureRegB == $past(upCounter)) else $error("fall capture");
   a_cap_ff_a: assert property ((capSel == CAP_FF) && edgeRise[2]
      |=> captureRegA == $past(upCounter)) else $error("ff capture");
   a_soft_cap: assert property (softCap
      |=> captureRegA == $past(upCounter)) else $error("soft capture");
   a_edge_irq: assert property (((capSel == CAP_PULSE) && edgeFall[0]) ||
      ((capSel != CAP_PULSE) && edgeRise[0]) |=> edgeInputIrq)
      else $error("edge interrupt missing");
   a_match_clear: assert property (countTick && atClear
      |=> upCounter == 16'h0000 ##1 upCounter <= 16'h0001)
      else $error("match clear wrong");
   a_overflow_irq: assert property (countTick && !atClear &&
      (upCounter == CNT_MAX) |=> overflowIrq && (upCounter == 16'h0000))
      else $error("overflow lost");
   a_stop_clear: assert property (!runTmr |=> upCounter == 16'h0000)
      else $error("stopped counter not clear");
   a_match_irq: assert property (matchFirstHit
      |=> matchIrqFirst && (upCounter == $past(compareRegFirst)))
      else $error("first match missing");
   a_ff_toggle: assert property (trigFirst && !ffWrite
      |=> timerOutputFirst != $past(timerOutputFirst))
      else $error("ff1 did not toggle");
   a_ff_soft: assert property (ffWrite && (ffCmd.softCtrlSecond == FF_SET)
      |=> timerOutputSecond) else $error("ff2 set failed");

endmodule : tcc_timer

/* tb/tcc_trigger_model.sv */
`timescale 1ns/1ps
module tcc_trigger_model (
   // clock
   input  wire logic clk,
   // trigger levels towards the timer
   output logic      trigFirst,
   output logic      trigSecond,
   output logic      ffLevel
);
   // idle low, so the first rise is a real edge
   initial begin
      trigFirst = 1'b0;
      trigSecond = 1'b0;
      ffLevel = 1'b0;
   end
   // one level change, held three clocks so the edge sampler sees it
   task automatic drive(input int sel, input logic v);
      @(posedge clk);
      case (sel)
         0: trigFirst <= v;
         1: trigSecond <= v;
         default: ffLevel <= v;
      endcase
      repeat (3) @(posedge clk);
   endtask : drive
endmodule : tcc_trigger_model

/* tb/tcc_timer_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
miscompares++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tcc_timer_bench;
   import tcc_pkg::*;
   logic       clk, rst_n, bWr, bRd, in1, in2, ffIn, m1, m2, ovf;
   logic       out1, out1En, out2, out2En, edgeIrq;
   logic [3:0] bAddr;
   logic [7:0] bWdata, bRdata;
   int         miscompares = 0, num_checks = 0, nM1 = 0, nM2 = 0, nEg = 0;
   int         nOv = 0;
   tcc_timer dut_u (.clk(clk), .rst_n(rst_n), .busAddr(bAddr),
      .busWdata(bWdata), .busWrite(bWr), .busRead(bRd), .busRdata(bRdata),
      .timerInputFirst(in1), .timerInputSecond(in2),
      .eightBitTimerFlipflop(ffIn), .timerOutputFirst(out1),
      .timerOutputFirstEn(out1En), .timerOutputSecond(out2),
      .timerOutputSecondEn(out2En), .matchIrqFirst(m1),
      .matchIrqSecond(m2), .overflowIrq(ovf), .edgeInputIrq(edgeIrq));
   tcc_trigger_model model_u (.clk(clk), .trigFirst(in1),
      .trigSecond(in2), .ffLevel(ffIn));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // irq pulses are one cycle, so tally them for later comparison
   always @(posedge clk) begin
      nM1 += m1;
      nM2 += m2;
      nEg += edgeIrq;
      nOv += ovf;
   end
   // idle cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bAddr <= a;
      bWdata <= d;
      bWr <= 1'b1;
      @(posedge clk);
      bWr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      bAddr <= a;
      bRd <= 1'b1;
      @(posedge clk);
      bRd <= 1'b0;
      #1 d = bRdata;
      @(posedge clk);
   endtask : rd
   // low byte then high byte back to back, one snapshot for both
   task automatic cap(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] g;
      bAddr <= a;
      bRd <= 1'b1;
      @(posedge clk);
      bAddr <= a + 4'h1;
      #1 g[7:0] = bRdata;
      @(posedge clk);
      bRd <= 1'b0;
      #1 g[15:8] = bRdata;
      @(posedge clk);
      `CHK("capture", e, g)
   endtask : cap
   task automatic pulses(input int n);
      repeat (n) begin
         model_u.drive(0, 1'b1);
         model_u.drive(0, 1'b0);
      end
   endtask : pulses
   task automatic t_reset();
      logic [7:0] d;
      rd(ADDR_RUN, d);
      `CHK("run", RUN_RST, d)
      rd(ADDR_FFCTRL, d);
      `CHK("ffctrl", FFCTRL_RST, d)
      rd(4'hE, d);
      `CHK("unmapped", 8'h00, d)
   endtask : t_reset
   // event counting, then soft capture; mode bit5 kept 1 except in soft capture writes
   task automatic t_event();
      wr(ADDR_RUN, 8'h00);
      wr(ADDR_MODE, 8'h20);
      wr(ADDR_RUN, 8'h81);
      pulses(5);
      wr(ADDR_MODE, 8'h00);
      cap(ADDR_CAPA_L, 16'h0005);
      cap(ADDR_CAPB_L, 16'h0000);
      wr(ADDR_CAPA_L, 8'h5A);
      wr(ADDR_CAPA_H, 8'hA5);
      cap(ADDR_CAPA_L, 16'h0005);
   endtask : t_event
   task automatic t_capsel();
      int e;
      wr(ADDR_MODE, 8'h28);
      model_u.drive(1, 1'b1);
      model_u.drive(1, 1'b0);
      cap(ADDR_CAPB_L, 16'h0005);
      e = nEg;
      model_u.drive(0, 1'b1);
      `CHK("edge rise", e + 1, nEg)
      model_u.drive(0, 1'b0);
      wr(ADDR_MODE, 8'h30);
      e = nEg;
      model_u.drive(0, 1'b1);
      `CHK("edge no rise", e, nEg)
      model_u.drive(0, 1'b0);
      `CHK("edge fall", e + 1, nEg)
      cap(ADDR_CAPB_L, 16'h0007);
      wr(ADDR_MODE, 8'h38);
      model_u.drive(2, 1'b1);
      pulses(1);
      model_u.drive(2, 1'b0);
      cap(ADDR_CAPA_L, 16'h0007);
      cap(ADDR_CAPB_L, 16'h0008);
   endtask : t_capsel
   // compare 2 and 3: clear on, then clear off with ff2 trigger
   task automatic t_match();
      int a, b;
      wr(ADDR_RUN, 8'h80);
      wr(ADDR_MODE, 8'h24);
      wr(ADDR_CMPF_L, 8'h02);
      wr(ADDR_CMPF_H, 8'h00);
      wr(ADDR_CMPS_L, 8'h03);
      wr(ADDR_CMPS_H, 8'h00);
      wr(ADDR_FFCTRL, 8'hD1);
      wr(ADDR_PORTFN, 8'h03);
      wr(ADDR_RUN, 8'h81);
      a = nM1;
      b = nM2;
      pulses(3);
      `CHK("match first", a + 1, nM1)
      `CHK("match second", b + 1, nM2)
      `CHK("ff first", 1'b1, out1)
      `CHK("pin enable", 1'b1, out1En)
      `CHK("pin enable 2", 1'b1, out2En)
      pulses(1);
      wr(ADDR_MODE, 8'h04);
      cap(ADDR_CAPA_L, 16'h0000);
      wr(ADDR_MODE, 8'hA0);
      pulses(4);
      wr(ADDR_MODE, 8'h80);
      cap(ADDR_CAPA_L, 16'h0004);
      `CHK("ff first", 1'b0, out1)
      `CHK("ff second", 1'b1, out2)
   endtask : t_match
   task automatic t_ffsoft();
      logic [7:0] c [6] = '{8'hC2, 8'hC1, 8'hC0, 8'h43, 8'h83, 8'h03};
      logic       x [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_FFCTRL, c[i]);
         `CHK("ff soft", x[i], (i < 3) ? out1 : out2)
      end
   endtask : t_ffsoft
   // /8 tap with clear at 3; the buffered 5 lands at the second match
   // and is never reached, so only one first match is seen
   task automatic t_dbuf();
      int a, b;
      wr(ADDR_RUN, 8'h00);
      wr(ADDR_DBCTL, 8'h01);
      wr(ADDR_CMPF_L, 8'h05);
      wr(ADDR_CMPF_H, 8'h00);
      wr(ADDR_MODE, 8'h26);
      a = nM1;
      b = nM2;
      wr(ADDR_RUN, 8'h81);
      repeat (60) @(posedge clk);
      wr(ADDR_MODE, 8'h06);
      `CHK("db match first", a + 1, nM1)
      `CHK("db match second", b + 2, nM2)
      `CHK("overflow", 0, nOv)
      cap(ADDR_CAPA_L, 16'h0003);
   endtask : t_dbuf
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   initial begin
      {rst_n, bWr, bRd, bAddr, bWdata} = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_event();
      t_capsel();
      t_match();
      t_ffsoft();
      t_dbuf();
      complete_run();
   end
   // the scenarios need a few hundred cycles at most
   initial begin
      #200us;
      miscompares++;
      complete_run();
   end
endmodule : tcc_timer_bench
